// >>> rtl/occ_top.sv
`timescale 1ns/100ps
module occ_top
    import occ_pkg::*;
#(
    parameter int unsigned WD_T0    = WD_T0_CYC,
    parameter int unsigned WD_T1    = WD_T1_CYC,
    parameter int unsigned WD_T2    = WD_T2_CYC,
    parameter int unsigned HOLD_LEN = HOLD_CYC,
    parameter int unsigned SC_LEN   = SC_REL_CYC
)(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        serial_setting_select,
    input  wire logic        glitch_filter_enable,
    input  wire logic        all_totem_pole_select,
    input  wire logic        output_enable,
    input  wire logic        global_open_wire_enable,
    input  wire logic        ch_in2,
    input  wire logic        ch_in3,
    input  wire logic        ch_in4,
    input  wire logic        timeout_monitor_enable,
    input  wire logic        timeout_error_out_i,
    input  wire logic        per_channel_setup_select,
    input  wire logic        wide_frame_select,
    input  wire logic        cs_n,
    input  wire logic        ser_wr,
    input  wire logic [15:0] ser_wr_data,
    input  wire logic        cfg_wr,
    input  wire logic        lower_pair_merge,
    input  wire logic        upper_pair_merge,
    input  wire logic [1:0]  timeout_select,
    input  wire logic        supply_ok,
    input  wire logic [7:0]  drv_overtemp,
    input  wire logic        chip_overtemp,
    input  wire logic [7:0]  open_load_det,
    input  wire logic [7:0]  short_det,
    output logic      [7:0]  channel_outputs_hs,
    output logic      [7:0]  channel_outputs_ls,
    output logic      [7:0]  slow_mode,
    output logic      [7:0]  open_wire_src_en,
    output logic      [7:0]  fault_led,
    output logic      [7:0]  level_led,
    output logic      [15:0] diag_frame,
    output logic             global_fault_o,
    output logic             global_fault_oe,
    output logic             timeout_error_out_o,
    output logic             timeout_error_out_oe
);
    typedef struct packed {
        logic [7:0]        out_set;
        logic [7:0]        cfg_ow;
        logic              low_merge;
        logic              up_merge;
        logic [1:0]        tsel;
        logic              cs_prev;
        logic [31:0]       wd_cnt;
        logic              wd_trip;
        logic [7:0][31:0]  hold;
        logic [7:0][31:0]  sc_cnt;
        logic [7:0]        slow;
        logic [7:0]        hs;
        logic [7:0]        ls;
        logic [7:0]        ow_src;
        logic [7:0]        fled;
        logic [7:0]        lled;
        logic [15:0]       diag;
        logic              gfault;
        logic              wd_oe;
    } occ_state_s;

    occ_state_s st_reg;
    occ_state_s st_next;

    occ_filt_if #(.W(NFILT)) flt ();

    occ_glitch_filt #(
        .W       (NFILT),
        .RST_VAL (FILT_RST)
    ) u_filt (
        .ref_clk (ref_clk),
        .rst     (rst),
        .fi      (flt)
    );

    assign flt.enable = glitch_filter_enable;
    assign flt.raw    = {cs_n, wide_frame_select, per_channel_setup_select, timeout_error_out_i,
                         timeout_monitor_enable, ch_in4, ch_in3, ch_in2, global_open_wire_enable}; // [RULE4]

    logic              ser;
    logic [7:0]        pin;
    logic              cs_f;
    logic [7:0]        demand;
    logic [7:0]        pp;
    logic [7:0]        ow_en;
    logic [7:0]        flt_on;
    logic [7:0]        drive;
    logic              wd_run;
    logic              cs_fall;
    logic              off_all;
    logic              any_fault;
    logic              drv_hot;
    logic              cond;
    logic [31:0]       wd_lim;

    always_comb begin
        st_next   = st_reg;
        ser       = serial_setting_select;
        pin       = flt.clean[7:0];
        cs_f      = flt.clean[POS_CS];
        demand    = '0;
        pp        = '0;
        ow_en     = '0;
        flt_on    = '0;
        drive     = '0;
        drv_hot   = 1'b0;
        cond      = 1'b0;
        any_fault = chip_overtemp; // [RULE19]

        // merge and timeout settings, held until rewritten
        if (cfg_wr) begin
            st_next.low_merge = lower_pair_merge;
            st_next.up_merge  = upper_pair_merge;
            st_next.tsel      = timeout_select;
        end

        // in serial mode the setup pin steers where a write lands
        if (ser && ser_wr) begin
            if (pin[POS_SETUP]) begin
                st_next.cfg_ow = ser_wr_data[7:0]; // [RULE1]
            end else begin
                st_next.out_set = ser_wr_data[7:0]; // [RULE1]
            end
        end

        // pins 7 and 8 act as channel inputs in parallel mode
        demand = ser ? st_reg.out_set : pin; // [RULE22] [RULE3] [RULE24]
        pp     = {8{all_totem_pole_select}}; // [RULE6]
        if (st_reg.low_merge) begin
            demand[1] = demand[0]; // [RULE8]
            demand[3] = demand[2]; // [RULE8]
            pp[3:0]   = 4'h0; // [RULE8]
        end
        if (st_reg.up_merge) begin
            demand[5] = demand[4]; // [RULE9]
            demand[7] = demand[6]; // [RULE9]
            pp[7:4]   = 4'h0; // [RULE9]
        end

        // watchdog on chip-select activity
        case (st_reg.tsel)
            TSEL_0P9:  wd_lim = WD_T0;
            TSEL_0P45: wd_lim = WD_T1;
            TSEL_0P15: wd_lim = WD_T2; // [RULE16]
            default:   wd_lim = WD_T0;
        endcase
        wd_run          = ser && pin[POS_TME];
        cs_fall         = st_reg.cs_prev && !cs_f;
        st_next.cs_prev = cs_f;
        if (!wd_run || cs_fall) begin
            st_next.wd_cnt  = 32'h0; // [RULE14]
            st_next.wd_trip = 1'b0; // [RULE15]
        end else if (!st_reg.wd_trip) begin
            if (st_reg.wd_cnt >= wd_lim - 32'h1) begin
                st_next.wd_trip = 1'b1; // [RULE15]
            end else begin
                st_next.wd_cnt = st_reg.wd_cnt + 32'h1;
            end
        end
        st_next.wd_oe = st_next.wd_trip; // [RULE15]

        off_all = !output_enable || chip_overtemp || st_reg.wd_trip; // [RULE7] [RULE15] [RULE19]

        // every channel's fault judged on its own detector inputs only
        for (int i = 0; i < NCH; i++) begin
            drv_hot  = supply_ok && drv_overtemp[i]; // [RULE17]
            ow_en[i] = !pp[i] && (st_reg.cfg_ow[i] || (ser && pin[POS_GOW])); // [RULE11] [RULE23]
            cond     = drv_hot || (ow_en[i] && open_load_det[i]); // [RULE10] [RULE18]
            if (cond) begin
                st_next.hold[i] = HOLD_LEN; // [RULE25] [RULE13]
            end else if (st_reg.hold[i] != 32'h0) begin
                st_next.hold[i] = st_reg.hold[i] - 32'h1; // [RULE25]
            end
            flt_on[i] = cond || (st_reg.hold[i] != 32'h0); // [RULE13]
            any_fault = any_fault || flt_on[i]; // [RULE5]

            drive[i]          = demand[i] && !drv_hot && !off_all; // [RULE21] [RULE17]
            st_next.hs[i]     = drive[i];
            st_next.ls[i]     = pp[i] && !demand[i] && !drv_hot && !off_all; // [RULE7] [RULE24]
            st_next.fled[i]   = flt_on[i] && output_enable; // [RULE18] [RULE7]
            st_next.lled[i]   = drive[i] && !flt_on[i] && output_enable; // [RULE7]

            // slow mode leaves once the input has stayed low long enough
            if (short_det[i]) begin
                st_next.slow[i]   = 1'b1; // [RULE20]
                st_next.sc_cnt[i] = 32'h0;
            end else if (st_reg.slow[i]) begin
                if (demand[i]) begin
                    st_next.sc_cnt[i] = 32'h0; // [RULE20]
                end else if (st_reg.sc_cnt[i] >= SC_LEN - 32'h1) begin
                    st_next.slow[i]   = 1'b0; // [RULE20]
                    st_next.sc_cnt[i] = 32'h0;
                end else begin
                    st_next.sc_cnt[i] = st_reg.sc_cnt[i] + 32'h1;
                end
            end
        end

        st_next.ow_src = ow_en & {8{output_enable}};
        st_next.gfault = any_fault; // [RULE5] [RULE19]
        if (ser && pin[POS_WIDE]) begin
            st_next.diag = {drive, flt_on}; // [RULE2]
        end else begin
            st_next.diag = {8'h00, flt_on}; // [RULE2] [RULE10]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_reg           <= '0;
            st_reg.cs_prev   <= CS_RST;
            st_reg.tsel      <= TSEL_RST;
            st_reg.low_merge <= MERGE_RST;
            st_reg.up_merge  <= MERGE_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign channel_outputs_hs   = st_reg.hs;
    assign channel_outputs_ls   = st_reg.ls;
    assign slow_mode            = st_reg.slow;
    assign open_wire_src_en     = st_reg.ow_src;
    assign fault_led            = st_reg.fled;
    assign level_led            = st_reg.lled;
    assign diag_frame           = st_reg.diag;
    assign global_fault_o       = 1'b0;
    assign global_fault_oe      = st_reg.gfault;
    assign timeout_error_out_o  = 1'b0;
    assign timeout_error_out_oe = st_reg.wd_oe;
endmodule

// >>> common/occ_pkg.sv
// Behaviour
// RULE1 - serial mode: setup select high writes configuration, low writes channel outputs
// RULE2 - serial mode: wide-frame select high gives 16-bit frames, low 8-bit frames
// RULE3 - parallel mode: setup select and wide-frame pins drive channels 7 and 8
// RULE4 - glitch filter enable filters all parallel inputs and chip select
// RULE5 - global error flag pulled low on driver shutdown or open-load fault
// RULE6 - totem-pole select high makes all channels push-pull, low all high-side
// RULE7 - output enable low: high-side off, push-pull high-Z, LEDs off
// RULE8 - lower merge pairs 1-2 and 3-4 from inputs 1, 3, no push-pull
// RULE9 - upper merge pairs 5-6 and 7-8 from inputs 5, 7, no push-pull
// RULE10 - each channel keeps own diagnostics while paired
// RULE11 - open-wire detection per channel or global, only on high-side channels
// RULE12 - host holds input and load stable for debounce time before trusting result
// RULE13 - open wire sets error bit, fault LED and global flag for 200ms minimum
// RULE14 - serial mode with timeout monitor on: chip-select fall restarts watchdog
// RULE15 - watchdog expiry turns all outputs off, timeout error low until next fall
// RULE16 - timeout select 00=0.9s, 01=0.45s, 10=0.15s; reset gives 0.9s
// RULE17 - overheated driver off while supply good, back on after hysteresis
// RULE18 - driver thermal shutdown sets global flag, error bit and fault LED
// RULE19 - chip overtemperature shuts all channels and asserts global flag
// RULE20 - short puts channel in slow mode until its input stays low 20ms
// RULE21 - fault on one channel leaves other channels operating normally
// RULE22 - serial select high: serial sets outputs; low: parallel pins; readback unaffected
// RULE23 - serial mode global open-wire enable covers all high-side channels
// RULE24 - parallel input 0 means off or low, 1 means on or high
// RULE25 - fault hold times are counters retriggered while fault persists
package occ_pkg;
    localparam int unsigned NCH          = 8;
    localparam int unsigned CLK_HZ       = 100_000_000;
    localparam int unsigned CYC_PER_MS   = CLK_HZ / 1000;
    localparam int unsigned WD_T0_MS     = 900;
    localparam int unsigned WD_T1_MS     = 450;
    localparam int unsigned WD_T2_MS     = 150;
    localparam int unsigned HOLD_MS      = 200;
    localparam int unsigned SC_REL_MS    = 20;
    localparam int unsigned WD_T0_CYC    = WD_T0_MS * CYC_PER_MS;
    localparam int unsigned WD_T1_CYC    = WD_T1_MS * CYC_PER_MS;
    localparam int unsigned WD_T2_CYC    = WD_T2_MS * CYC_PER_MS;
    localparam int unsigned HOLD_CYC     = HOLD_MS * CYC_PER_MS;
    localparam int unsigned SC_REL_CYC   = SC_REL_MS * CYC_PER_MS;
    localparam int unsigned FILT_CW      = 3;
    localparam logic [2:0]  FILT_LAST    = 3'h3;
    localparam int unsigned NFILT        = 9;
    localparam int unsigned POS_GOW      = 0;
    localparam int unsigned POS_TME      = 4;
    localparam int unsigned POS_SETUP    = 6;
    localparam int unsigned POS_WIDE     = 7;
    localparam int unsigned POS_CS       = 8;
    localparam logic [8:0]  FILT_RST     = 9'h100;
    localparam logic [1:0]  TSEL_0P9     = 2'h0;
    localparam logic [1:0]  TSEL_0P45    = 2'h1;
    localparam logic [1:0]  TSEL_0P15    = 2'h2;
    localparam logic [1:0]  TSEL_RST     = TSEL_0P9;
    localparam logic        MERGE_RST    = 1'h0;
    localparam logic        CS_RST       = 1'h1;
endpackage

// >>> common/occ_filt_if.sv
`timescale 1ns/100ps
interface occ_filt_if #(parameter int W = 9);
    logic [W-1:0] raw;
    logic [W-1:0] clean;
    logic         enable;
    modport filt (input raw, input enable, output clean);
    modport user (output raw, output enable, input clean);
endinterface

// >>> rtl/occ_glitch_filt.sv
`timescale 1ns/100ps
module occ_glitch_filt
    import occ_pkg::*;
#(
    parameter int         W       = 9,
    parameter logic [8:0] RST_VAL = FILT_RST
)(
    input  wire logic ref_clk,
    input  wire logic rst,
    occ_filt_if.filt  fi
);
    typedef struct packed {
        logic [W-1:0]              clean;
        logic [W-1:0][FILT_CW-1:0] cnt;
    } occ_flt_s;

    occ_flt_s flt_reg;
    occ_flt_s flt_next;

    // with the filter enabled, a bit follows its input only after a change holds for several samples
    always_comb begin
        flt_next = flt_reg;
        for (int i = 0; i < W; i++) begin
            if (!fi.enable) begin
                flt_next.clean[i] = fi.raw[i];
                flt_next.cnt[i]   = '0;
            end else if (fi.raw[i] == flt_reg.clean[i]) begin
                flt_next.cnt[i] = '0; // [RULE4]
            end else if (flt_reg.cnt[i] == FILT_LAST) begin
                flt_next.clean[i] = fi.raw[i];
                flt_next.cnt[i]   = '0;
            end else begin
                flt_next.cnt[i] = flt_reg.cnt[i] + 3'h1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            flt_reg       <= '0;
            flt_reg.clean <= RST_VAL[W-1:0];
        end else begin
            flt_reg <= flt_next;
        end
    end

    assign fi.clean = flt_reg.clean;
endmodule

// >>> tb/occ_pin_model.sv
`timescale 1ns/100ps
module occ_pin_model (
    input  wire logic od_oe,
    input  wire logic host_lvl,
    output logic      pin_lvl
);
    // host level unless the device sinks the shared pin
    assign pin_lvl = od_oe ? 1'b0 : host_lvl;
endmodule

// >>> tb/occ_top_sva.sv
`timescale 1ns/100ps
module occ_top_chk
    import occ_pkg::*;
#(
    parameter int unsigned HOLD_LEN = HOLD_CYC
)(
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        output_enable,
    input wire logic        all_totem_pole_select,
    input wire logic        chip_overtemp,
    input wire logic        supply_ok,
    input wire logic [7:0]  drv_overtemp,
    input wire logic [7:0]  open_load_det,
    input wire logic [7:0]  short_det,
    input wire logic [7:0]  channel_outputs_hs,
    input wire logic [7:0]  channel_outputs_ls,
    input wire logic [7:0]  slow_mode,
    input wire logic [7:0]  open_wire_src_en,
    input wire logic [7:0]  fault_led,
    input wire logic [7:0]  level_led,
    input wire logic [15:0] diag_frame,
    input wire logic        global_fault_o,
    input wire logic        global_fault_oe,
    input wire logic        timeout_error_out_o,
    input wire logic        timeout_error_out_oe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic [31:0] quiet_reg;
    logic [31:0] quiet_next;
    logic        cause;
    logic [7:0]  drv;
    logic [7:0]  lit;
    // cycles since the last held fault cause
    assign cause = (supply_ok && drv_overtemp != 8'h00) || (open_load_det & open_wire_src_en) != 8'h00;
    assign drv = channel_outputs_hs | channel_outputs_ls;
    assign lit = drv | fault_led | level_led | open_wire_src_en;
    always_comb begin
        quiet_next = quiet_reg + 32'h1;
        if (cause) quiet_next = 32'h0;
        else if (quiet_reg >= HOLD_LEN + 8) quiet_next = quiet_reg;
    end
    always_ff @(posedge ref_clk) begin
        if (rst) quiet_reg <= HOLD_LEN + 8;
        else quiet_reg <= quiet_next;
    end
    chk_oe_blank: assert property (!output_enable |=> lit == 8'h00)
        else $error("outputs active with output enable low");
    chk_drive_excl: assert property ((channel_outputs_hs & channel_outputs_ls) == 8'h00)
        else $error("high and low drive on together");
    chk_high_side: assert property (!all_totem_pole_select |=> channel_outputs_ls == 8'h00)
        else $error("low side on in high-side mode");
    chk_chip_hot: assert property (chip_overtemp |=> drv == 8'h00 && global_fault_oe)
        else $error("chip overtemperature not handled");
    chk_driver_hot: assert property (supply_ok && drv_overtemp != 8'h00 |=>
        (drv & $past(drv_overtemp)) == 8'h00 && global_fault_oe
        && (diag_frame[7:0] & $past(drv_overtemp)) == $past(drv_overtemp))
        else $error("hot driver not shut down or flagged");
    chk_od_data: assert property (global_fault_o == 1'b0 && timeout_error_out_o == 1'b0)
        else $error("open-drain data not low");
    chk_trip_off: assert property (timeout_error_out_oe && $past(timeout_error_out_oe) |-> drv == 8'h00)
        else $error("outputs on after watchdog trip");
    chk_slow_set: assert property (short_det != 8'h00 |=> (slow_mode & $past(short_det)) == $past(short_det))
        else $error("short did not enter slow mode");
    chk_hold_min: assert property ($fell(global_fault_oe) && !$past(chip_overtemp, 2) |->
        quiet_reg >= HOLD_LEN - 1)
        else $error("fault flag released early");
    chk_hold_max: assert property (quiet_reg == HOLD_LEN + 4 && !chip_overtemp && !$past(chip_overtemp) |->
        !global_fault_oe)
        else $error("fault flag held too long");
    cover property ($rose(timeout_error_out_oe));
    cover property ($fell(slow_mode[0]));
    cover property ($fell(global_fault_oe));
endmodule
bind occ_top occ_top_chk #(.HOLD_LEN(HOLD_LEN)) occ_top_chk_i (.*);

// >>> tb/occ_top_test.sv
`timescale 1ns/100ps
module occ_top_test;
    import occ_pkg::*;
    localparam int unsigned HL = 20;
    localparam int unsigned SL = 10;
    logic        ref_clk, rst, serial_setting_select, glitch_filter_enable, all_totem_pole_select;
    logic        output_enable, cs_n, ser_wr, cfg_wr, lower_pair_merge, upper_pair_merge;
    logic        supply_ok, chip_overtemp, timeout_error_out_i, global_fault_o, global_fault_oe;
    logic        timeout_error_out_o, timeout_error_out_oe, ch_in2, ch_in3, ch_in4;
    logic        global_open_wire_enable, timeout_monitor_enable, per_channel_setup_select, wide_frame_select;
    logic [7:0]  pin, drv_overtemp, open_load_det, short_det, channel_outputs_hs, channel_outputs_ls;
    logic [7:0]  slow_mode, open_wire_src_en, fault_led, level_led;
    logic [15:0] ser_wr_data, diag_frame;
    logic [1:0]  timeout_select;
    logic [24:0] rows [5] = '{25'h0A5A500, 25'h1A5A55A, 25'h10000FF, 25'h0FFFF00, 25'h03C3C00};
    int          lim [3] = '{90, 45, 15};
    int          error_cnt, n_tests;
    assign {wide_frame_select, per_channel_setup_select} = pin[7:6];
    assign {timeout_monitor_enable, ch_in4, ch_in3, ch_in2, global_open_wire_enable} = pin[4:0];
    occ_top #(.WD_T0(90), .WD_T1(45), .WD_T2(15), .HOLD_LEN(HL), .SC_LEN(SL)) occ_top_i (.*);
    occ_pin_model occ_pin_model_i (.od_oe(timeout_error_out_oe), .host_lvl(pin[5]), .pin_lvl(timeout_error_out_i));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic go(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // c high: config pulse, else serial frame
    task automatic wr(input logic c, input logic [15:0] d);
        @(posedge ref_clk) begin
            ser_wr <= ~c;
            cfg_wr <= c;
            ser_wr_data <= d;
        end
        @(posedge ref_clk) {ser_wr, cfg_wr} <= 2'h0;
    endtask
    task automatic conclude;
        $display("errors=%0d checks=%0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #100000;
        error_cnt++;
        conclude();
    end
    initial begin
        {error_cnt, n_tests} = '0;
        {rst, cs_n, output_enable, supply_ok} = 4'hF;
        {serial_setting_select, glitch_filter_enable, all_totem_pole_select, ser_wr, cfg_wr} = 5'h00;
        {lower_pair_merge, upper_pair_merge, chip_overtemp, timeout_select, ser_wr_data} = '0;
        {pin, drv_overtemp, open_load_det, short_det} = '0;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        go(1);
        chk(channel_outputs_hs | slow_mode | fault_led, 8'h00);
        chk({6'h00, global_fault_oe, timeout_error_out_oe}, 8'h00);
        foreach (rows[k]) begin
            @(posedge ref_clk) {all_totem_pole_select, pin} <= rows[k][24:16];
            go(3);
            chk(channel_outputs_hs, rows[k][15:8]);
            chk(channel_outputs_ls, rows[k][7:0]);
        end
        @(posedge ref_clk) {glitch_filter_enable, pin} <= 9'h102;
        @(posedge ref_clk);
        @(posedge ref_clk) pin <= 8'h00;
        go(1);
        chk(channel_outputs_hs, 8'h3C);
        go(6);
        chk(channel_outputs_hs, 8'h00);
        @(posedge ref_clk) pin <= 8'h02;
        go(3);
        chk(channel_outputs_hs, 8'h00);
        go(4);
        chk(channel_outputs_hs, 8'h02);
        @(posedge ref_clk) {glitch_filter_enable, output_enable, pin} <= 10'h0FF;
        go(3);
        chk(channel_outputs_hs | level_led | fault_led, 8'h00);
        @(posedge ref_clk) output_enable <= 1'b1;
        @(posedge ref_clk) drv_overtemp <= 8'h04;
        go(3);
        chk(channel_outputs_hs, 8'hFB);
        chk(fault_led & diag_frame[7:0], 8'h04);
        chk(level_led, 8'hFB);
        @(posedge ref_clk) drv_overtemp <= 8'h00;
        go(HL / 2);
        chk({fault_led[7:1], global_fault_oe}, 8'h05);
        go(HL);
        chk({fault_led[7:1], global_fault_oe}, 8'h00);
        chk(channel_outputs_hs, 8'hFF);
        @(posedge ref_clk) {supply_ok, drv_overtemp} <= 9'h004;
        go(3);
        chk(channel_outputs_hs | fault_led, 8'hFF);
        @(posedge ref_clk) {supply_ok, drv_overtemp} <= 9'h100;
        @(posedge ref_clk) chip_overtemp <= 1'b1;
        go(3);
        chk({channel_outputs_hs[7:1], global_fault_oe}, 8'h01);
        @(posedge ref_clk) {all_totem_pole_select, lower_pair_merge, upper_pair_merge, chip_overtemp} <= 4'hE;
        wr(1'b1, 16'h0000);
        @(posedge ref_clk) {drv_overtemp, pin} <= 16'h0255;
        go(3);
        chk(channel_outputs_hs, 8'hFD);
        chk(fault_led | channel_outputs_ls, 8'h02);
        @(posedge ref_clk) {drv_overtemp, pin} <= 16'h00AA;
        go(3);
        chk(channel_outputs_hs | channel_outputs_ls, 8'h00);
        @(posedge ref_clk) {all_totem_pole_select, lower_pair_merge, upper_pair_merge, pin} <= 11'h003;
        wr(1'b1, 16'h0000);
        @(posedge ref_clk) short_det <= 8'h01;
        @(posedge ref_clk) short_det <= 8'h00;
        go(SL + 5);
        chk({slow_mode[3:0], channel_outputs_hs[3:0]}, 8'h13);
        @(posedge ref_clk) pin <= 8'h00;
        go(SL - 1);
        chk(slow_mode, 8'h01);
        go(8);
        chk(slow_mode, 8'h00);
        @(posedge ref_clk) {serial_setting_select, pin} <= 9'h100;
        wr(1'b0, 16'h00C3);
        @(posedge ref_clk) pin <= 8'h0E;
        go(3);
        chk(channel_outputs_hs, 8'hC3);
        chk(diag_frame[15:8], 8'h00);
        @(posedge ref_clk) pin <= 8'h80;
        go(3);
        chk(diag_frame[15:8], 8'hC3);
        @(posedge ref_clk) pin <= 8'h40;
        go(3);
        wr(1'b0, 16'h0001);
        @(posedge ref_clk) open_load_det <= 8'h01;
        go(3);
        chk(open_wire_src_en, 8'h01);
        chk(channel_outputs_hs, 8'hC3);
        chk({global_fault_oe, fault_led[6:0]}, 8'h81);
        chk(diag_frame[7:0], 8'h01);
        @(posedge ref_clk) {open_load_det, pin} <= 16'h0041;
        go(3);
        chk(open_wire_src_en, 8'hFF);
        @(posedge ref_clk) all_totem_pole_select <= 1'b1;
        go(3);
        chk(open_wire_src_en, 8'h00);
        @(posedge ref_clk) {rst, all_totem_pole_select, pin} <= 10'h210;
        @(posedge ref_clk) rst <= 1'b0;
        wr(1'b0, 16'h00FF);
        for (int k = 0; k < 3; k++) begin
            @(posedge ref_clk) timeout_select <= k[1:0];
            if (k > 0) wr(1'b1, 16'h0000);
            @(posedge ref_clk) cs_n <= 1'b0;
            @(posedge ref_clk) cs_n <= 1'b1;
            go(lim[k] - 8);
            chk({channel_outputs_hs[7:1], timeout_error_out_oe}, 8'hFE);
            go(14);
            chk({channel_outputs_hs[7:1], timeout_error_out_oe}, 8'h01);
            @(posedge ref_clk) cs_n <= 1'b0;
            @(posedge ref_clk) cs_n <= 1'b1;
            go(5);
            chk({channel_outputs_hs[7:1], timeout_error_out_oe}, 8'hFE);
        end
        conclude();
    end
endmodule
